/* tb/mod_data_mem.sv */
/*
  banked data memory model, 4096 bytes.
  assumes read strobe in q2, data used in q3, write strobe in q4.
*/
`timescale 1ns/10ps
module mod_data_mem (
  input wire logic core_clk_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [0:4095];
  logic rd_q;
  logic [7:0] junk;
  initial begin
    rd_q = 1'b0;
    junk = 8'hA5;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
  end
  // data only in the phase after the read strobe, a changing pattern otherwise
  always @(posedge core_clk_i) begin
    rd_q <= mem_rd_i;
    junk <= ~junk + 8'h01;
    if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
  end
  assign mem_rdata_o = rd_q ? mem[mem_addr_i] : junk;
endmodule

/* tb/mod_decode_props.sv */
/*
  port checker for the move/or decoder.
  assumes it is bound to mod_decode and sees its ports only.
*/
`timescale 1ns/10ps
module mod_decode_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic skip_i,
  input wire logic [11:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [7:0] accum_o,
  input wire logic [7:0] bank_select_reg_o,
  input wire logic flag_zero_o,
  input wire logic cycle_end_o,
  input mod_pkg::mod_phase_type phase_o
);
  // ---------------
  // assertions
  // ---------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = phase_o == mod_pkg::PH_Q4 && !skip_i;
  phase_order_a: assert property (phase_o == mod_pkg::PH_Q1 |=> phase_o == mod_pkg::PH_Q2
    ##1 phase_o == mod_pkg::PH_Q3 ##1 phase_o == mod_pkg::PH_Q4) else $error("phase order broken");
  read_phase_a: assert property (mem_rd_o |-> phase_o == mod_pkg::PH_Q2)
    else $error("read outside q2");
  write_phase_a: assert property (mem_wr_o |-> phase_o == mod_pkg::PH_Q4 && cycle_end_o)
    else $error("write outside q4");
  bank_upper_a: assert property (bank_select_reg_o[7:4] == 4'h0)
    else $error("bank upper bits set");
  acc_literal_a: assert property (take && instr_i[15:8] == mod_pkg::OP_LOAD_ACC |->
    ##5 accum_o == $past(instr_i[7:0], 5)) else $error("literal not in accumulator");
  flag_keep_a: assert property (take && instr_i[15:8] == mod_pkg::OP_LOAD_ACC |->
    ##5 flag_zero_o == $past(flag_zero_o, 4)) else $error("literal load changed zero flag");
  bank_load_a: assert property (take && instr_i[15:8] == mod_pkg::OP_LOAD_BANK |->
    ##5 bank_select_reg_o == {4'h0, $past(instr_i[3:0], 5)}) else $error("bank load wrong");
  access_addr_a: assert property (take && !instr_i[mod_pkg::ACCESS_BIT] &&
    (instr_i[15:10] == mod_pkg::OP_OR_FILE || instr_i[15:10] == mod_pkg::OP_MOVE_FILE) |->
    ##2 mem_addr_o == {{4{$past(instr_i[7], 2)}}, $past(instr_i[7:0], 2)}) else $error("access address wrong");
  store_data_a: assert property (take && instr_i[15:9] == mod_pkg::OP_STORE_ACC |->
    ##4 mem_wr_o && mem_wdata_o == accum_o) else $error("store data wrong");
  cover property (mem_wr_o);
  cover property (take && instr_i[15:12] == mod_pkg::OP_MOVE_FF);
  cover property (take && instr_i[15:6] == mod_pkg::OP_LOAD_PTR);
endmodule
bind mod_decode mod_decode_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .instr_i(instr_i),
  .skip_i(skip_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_wdata_o(mem_wdata_o), .accum_o(accum_o), .bank_select_reg_o(bank_select_reg_o),
  .flag_zero_o(flag_zero_o), .cycle_end_o(cycle_end_o), .phase_o(phase_o));

/* tb/tb.sv */
/*
  testbench for the move/or decoder.
  assumes the data memory model beside it and the bound checker.
*/
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [15:0] w1; logic [15:0] w2; logic ext; logic [7:0] acc; logic neg; logic zero; logic [7:0] bank_select_reg;
  } mod_row_type;
  logic core_clk_i, rst_i, ext_set_en_i, skip_i, mem_rd_o, mem_wr_o, indexed_mode_o;
  logic flag_neg_o, flag_zero_o, unhandled_o, cycle_end_o;
  logic [15:0] instr_i;
  logic [7:0] mem_rdata_i, mem_wdata_o, accum_o, bank_select_reg_o;
  logic [11:0] mem_addr_o, indirect_pointer0_o, indirect_pointer1_o, indirect_pointer2_o;
  mod_pkg::mod_phase_type phase_o;
  int n_fail, check_count, cyc;
  mod_row_type rows [10];
  mod_decode dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .instr_i(instr_i), .ext_set_en_i(ext_set_en_i),
    .skip_i(skip_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .indexed_mode_o(indexed_mode_o), .accum_o(accum_o),
    .bank_select_reg_o(bank_select_reg_o), .flag_neg_o(flag_neg_o), .flag_zero_o(flag_zero_o),
    .indirect_pointer0_o(indirect_pointer0_o), .indirect_pointer1_o(indirect_pointer1_o),
    .indirect_pointer2_o(indirect_pointer2_o), .unhandled_o(unhandled_o), .cycle_end_o(cycle_end_o),
    .phase_o(phase_o));
  mod_data_mem m (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  // ---------------
  // helpers
  // ---------------
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [15:0] w, input logic s);
    @(negedge core_clk_i);
    while (phase_o !== mod_pkg::PH_Q4) @(negedge core_clk_i);
    instr_i = w;
    skip_i = s;
  endtask
  task automatic run(input logic [15:0] w1, input logic [15:0] w2);
    issue(w1, 1'b0);
    if (w2 != 16'h0000) issue(w2, 1'b0);
    issue(16'h0000, 1'b0);
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  // ---------------
  // tests
  // ---------------
  initial begin
    rst_i = 1'b1; instr_i = 16'h0000; ext_set_en_i = 1'b0; skip_i = 1'b0;
    n_fail = 0; check_count = 0; cyc = 0;
    rows = '{'{16'h0E91, 16'h0000, 1'b0, 8'h91, 1'b0, 1'b0, 8'h00},
      '{16'h1025, 16'h0000, 1'b0, 8'h93, 1'b1, 1'b0, 8'h00},
      '{16'h01F5, 16'h0000, 1'b0, 8'h93, 1'b1, 1'b0, 8'h05},
      '{16'h5122, 16'h0000, 1'b0, 8'h00, 1'b0, 1'b1, 8'h05},
      '{16'h0E4F, 16'h0000, 1'b0, 8'h4F, 1'b0, 1'b1, 8'h05},
      '{16'h6F30, 16'h0000, 1'b0, 8'h4F, 1'b0, 1'b1, 8'h05},
      '{16'h1331, 16'h0000, 1'b0, 8'h4F, 1'b1, 1'b0, 8'h05},
      '{16'hC530, 16'hF123, 1'b0, 8'h4F, 1'b1, 1'b0, 8'h05},
      '{16'hEE23, 16'hF0AB, 1'b0, 8'h4F, 1'b1, 1'b0, 8'h05},
      '{16'h5010, 16'h0000, 1'b1, 8'h7E, 1'b0, 1'b0, 8'h05}};
    #1;
    m.mem[12'h025] = 8'h13; m.mem[12'h522] = 8'h00; m.mem[12'h531] = 8'h80; m.mem[12'h010] = 8'h7E;
    repeat (6) @(negedge core_clk_i);
    chk(accum_o, 12'h000);
    chk(phase_o, 12'h001);
    rst_i = 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      ext_set_en_i = rows[i].ext;
      run(rows[i].w1, rows[i].w2);
      chk(accum_o, rows[i].acc);
      chk(flag_neg_o, rows[i].neg);
      chk(flag_zero_o, rows[i].zero);
      chk(bank_select_reg_o, rows[i].bank_select_reg);
      $display("row %0d done", i);
    end
    chk(m.mem[12'h530], 12'h04F);
    chk(m.mem[12'h531], 12'h0CF);
    chk(m.mem[12'h123], 12'h04F);
    chk(indirect_pointer2_o, 12'h3AB);
    ext_set_en_i = 1'b0;
    issue(16'hEE0F, 1'b0);
    issue(16'hF0FF, 1'b0);
    run(16'hEE15, 16'hF000);
    chk(indirect_pointer0_o, 12'hFFF);
    chk(indirect_pointer1_o, 12'h500);
    $display("pointer test done");
    issue(16'hEE33, 1'b0);
    @(negedge core_clk_i);
    chk(unhandled_o, 12'h001);
    run(16'hF0CD, 16'h0000);
    chk(indirect_pointer2_o, 12'h3AB);
    $display("refused index test done");
    issue(16'h0E55, 1'b1);
    run(16'h0000, 16'h0000);
    chk(accum_o, 12'h07E);
    $display("skip test done");
    ext_set_en_i = 1'b1;
    issue(16'h5210, 1'b0);
    repeat (2) @(negedge core_clk_i);
    chk(indexed_mode_o, 12'h001);
    issue(16'h5260, 1'b0);
    repeat (2) @(negedge core_clk_i);
    chk(indexed_mode_o, 12'h000);
    ext_set_en_i = 1'b0;
    $display("indexed flag test done");
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    chk(indirect_pointer0_o, 12'h000);
    chk(bank_select_reg_o, 12'h000);
    chk(phase_o, 12'h001);
    rst_i = 1'b0;
    run(16'h0E3C, 16'h0000);
    chk(accum_o, 12'h03C);
    $display("mid-run reset test done");
    print_verdict;
  end
endmodule

/* verilog/mod_decode.sv */
/*
  decoder and executor for the or/move/literal/pointer-load subset of an 8-bit core.
  assumes program word is taken at the q4 edge of each instruction cycle and data memory read data is valid
  the phase after the read address is presented. other opcodes are passed through as unhandled.
*/
`timescale 1ns/10ps
module mod_decode (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic skip_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [11:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic indexed_mode_o,
  output logic [7:0] accum_o,
  output logic [7:0] bank_select_reg_o,
  output logic flag_neg_o,
  output logic flag_zero_o,
  output logic [11:0] indirect_pointer0_o,
  output logic [11:0] indirect_pointer1_o,
  output logic [11:0] indirect_pointer2_o,
  output logic unhandled_o,
  output logic cycle_end_o,
  output mod_pkg::mod_phase_type phase_o
);
  mod_pkg::mod_state_type state;
  logic [15:0] ir;
  logic [7:0] result;
  logic [7:0] read_data;
  logic [7:0] write_value;
  logic [1:0] ptr_sel;
  logic [3:0] ptr_high;
  logic [11:0] file_addr;
  logic [11:0] next_addr;
  logic is_or, is_move_file, is_store, is_bank, is_lit, is_ptr, is_ff;
  logic use_access, use_indexed;

  // --------------------------------
  // phase sequencer
  // --------------------------------
  mod_phase_gen u_phase (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .phase_o(phase_o)
  );

  // --------------------------------
  // opcode decode
  // --------------------------------
  assign is_or = (ir[15:10] == mod_pkg::OP_OR_FILE);
  assign is_move_file = (ir[15:10] == mod_pkg::OP_MOVE_FILE);
  assign is_store = (ir[15:9] == mod_pkg::OP_STORE_ACC);
  assign is_bank = (ir[15:8] == mod_pkg::OP_LOAD_BANK);
  assign is_lit = (ir[15:8] == mod_pkg::OP_LOAD_ACC);
  assign is_ptr = (ir[15:6] == mod_pkg::OP_LOAD_PTR) && (ir[5:4] <= mod_pkg::PTR_INDEX_MAX);
  assign is_ff = (ir[15:12] == mod_pkg::OP_MOVE_FF);
  assign use_access = !ir[mod_pkg::ACCESS_BIT];
  assign use_indexed = use_access && ext_set_en_i && (ir[7:0] <= mod_pkg::INDEXED_LIMIT);

  // --------------------------------
  // byte address formation
  // --------------------------------
  always_comb begin
    if (!use_access) begin
      file_addr = {bank_select_reg_o[3:0], ir[7:0]};
    end else if (ir[7:0] < mod_pkg::ACCESS_SPLIT) begin
      file_addr = {4'h0, ir[7:0]};
    end else begin
      file_addr = {mod_pkg::ACCESS_HIGH_BANK, ir[7:0]};
    end
  end

  always_comb begin
    next_addr = file_addr;
    if (state == mod_pkg::ST_FF_DEST || (state == mod_pkg::ST_FETCH && is_ff)) begin
      next_addr = ir[11:0];
    end
  end

  // --------------------------------
  // instruction register, state
  // --------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ir <= 16'h0000;
      state <= mod_pkg::ST_FETCH;
    end else if (phase_o == mod_pkg::PH_Q4) begin
      ir <= instr_i;
      case (state)
        mod_pkg::ST_FETCH: begin
          if (is_ptr) begin
            state <= mod_pkg::ST_PTR_LOW;
          end else if (is_ff) begin
            state <= mod_pkg::ST_FF_DEST;
          end else if (skip_i) begin
            state <= mod_pkg::ST_FF_SKIP;
          end
        end
        mod_pkg::ST_FF_SKIP: begin
          if (is_ff || is_ptr) begin
            state <= mod_pkg::ST_IDLE;
          end else begin
            state <= skip_i ? mod_pkg::ST_FF_SKIP : mod_pkg::ST_FETCH;
          end
        end
        default: state <= skip_i ? mod_pkg::ST_FF_SKIP : mod_pkg::ST_FETCH;
      endcase
    end
  end

  // --------------------------------
  // operand read and process
  // --------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      read_data <= mod_pkg::BYTE_RESET;
    end else if (phase_o == mod_pkg::PH_Q3 && state == mod_pkg::ST_FETCH) begin
      read_data <= mem_rdata_i;
    end
  end

  always_comb begin
    result = read_data;
    if (is_or) begin
      result = accum_o | read_data;
    end else if (is_store) begin
      result = accum_o;
    end
  end

  // or/move write data is taken from the live read bus, read_data only lands at the same edge
  always_comb begin
    write_value = mem_rdata_i;
    if (state == mod_pkg::ST_FF_DEST) begin
      write_value = read_data;
    end else if (is_or) begin
      write_value = accum_o | mem_rdata_i;
    end else if (is_store) begin
      write_value = accum_o;
    end
  end

  // --------------------------------
  // memory strobes
  // --------------------------------
  logic active;
  assign active = (state == mod_pkg::ST_FETCH) || (state == mod_pkg::ST_PTR_LOW) || (state == mod_pkg::ST_FF_DEST);
  assign mem_rd_o = (phase_o == mod_pkg::PH_Q2) && (state == mod_pkg::ST_FETCH) &&
    (is_or || is_move_file || is_ff);
  assign mem_wr_o = (phase_o == mod_pkg::PH_Q4) && (((state == mod_pkg::ST_FETCH) &&
    ((is_or || is_move_file) && ir[mod_pkg::DEST_BIT] || is_store)) || (state == mod_pkg::ST_FF_DEST));
  assign cycle_end_o = (phase_o == mod_pkg::PH_Q4);
  assign unhandled_o = active && (state == mod_pkg::ST_FETCH) &&
    !(is_or || is_move_file || is_store || is_bank || is_lit || is_ptr || is_ff);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_addr_o <= mod_pkg::ADDR_RESET;
      indexed_mode_o <= 1'b0;
    end else if (phase_o == mod_pkg::PH_Q1) begin
      mem_addr_o <= next_addr;
      indexed_mode_o <= (is_or || is_move_file || is_store) && use_indexed && (state == mod_pkg::ST_FETCH);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_wdata_o <= mod_pkg::BYTE_RESET;
    end else if (phase_o == mod_pkg::PH_Q3) begin
      mem_wdata_o <= write_value;
    end
  end

  // --------------------------------
  // core registers and flags
  // --------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      accum_o <= mod_pkg::BYTE_RESET;
      bank_select_reg_o <= mod_pkg::BYTE_RESET;
      flag_neg_o <= 1'b0;
      flag_zero_o <= 1'b0;
    end else if (phase_o == mod_pkg::PH_Q4 && state == mod_pkg::ST_FETCH) begin
      if ((is_or || is_move_file) && !ir[mod_pkg::DEST_BIT]) begin
        accum_o <= result;
      end
      if (is_or || is_move_file) begin
        flag_neg_o <= result[7];
        flag_zero_o <= (result == 8'h00);
      end
      if (is_lit) begin
        accum_o <= ir[7:0];
      end
      if (is_bank) begin
        bank_select_reg_o <= {4'h0, ir[3:0]};
      end
    end
  end

  // --------------------------------
  // pointer load
  // --------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ptr_sel <= 2'h0;
      ptr_high <= 4'h0;
      indirect_pointer0_o <= mod_pkg::ADDR_RESET;
      indirect_pointer1_o <= mod_pkg::ADDR_RESET;
      indirect_pointer2_o <= mod_pkg::ADDR_RESET;
    end else if (phase_o == mod_pkg::PH_Q4) begin
      if (state == mod_pkg::ST_FETCH && is_ptr) begin
        ptr_sel <= ir[5:4];
        ptr_high <= ir[3:0];
        case (ir[5:4])
          2'h0: indirect_pointer0_o[11:8] <= ir[3:0];
          2'h1: indirect_pointer1_o[11:8] <= ir[3:0];
          default: indirect_pointer2_o[11:8] <= ir[3:0];
        endcase
      end else if (state == mod_pkg::ST_PTR_LOW && ir[15:8] == mod_pkg::PTR_SECOND_PREFIX) begin
        case (ptr_sel)
          2'h0: indirect_pointer0_o <= {ptr_high, ir[7:0]};
          2'h1: indirect_pointer1_o <= {ptr_high, ir[7:0]};
          default: indirect_pointer2_o <= {ptr_high, ir[7:0]};
        endcase
      end
    end
  end
endmodule

/* verilog/mod_phase_gen.sv */
/*
  four-phase sequencer: steps one phase per core clock.
  assumes synchronous active-high reset.
*/
`timescale 1ns/10ps
module mod_phase_gen (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output mod_pkg::mod_phase_type phase_o
);
  // --------------------------------
  // phase rotation
  // --------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      phase_o <= mod_pkg::PH_Q1;
    end else begin
      case (phase_o)
        mod_pkg::PH_Q1: phase_o <= mod_pkg::PH_Q2;
        mod_pkg::PH_Q2: phase_o <= mod_pkg::PH_Q3;
        mod_pkg::PH_Q3: phase_o <= mod_pkg::PH_Q4;
        default: phase_o <= mod_pkg::PH_Q1;
      endcase
    end
  end
endmodule

/* verilog/mod_pkg.sv */
/*
  package for the move/or instruction subset decoder: opcode patterns, field positions, phase codes, reset values.
  assumes one core clock with a quarter-phase sequencer and banked data memory with one-cycle read data.
*/
package mod_pkg;
  localparam logic [5:0] OP_OR_FILE = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE = 6'h14;
  localparam logic [6:0] OP_STORE_ACC = 7'h37;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] OP_LOAD_ACC = 8'h0E;
  localparam logic [9:0] OP_LOAD_PTR = 10'h3B8;
  localparam logic [3:0] OP_MOVE_FF = 4'hC;
  localparam logic [3:0] OP_SECOND_WORD = 4'hF;
  localparam logic [7:0] PTR_SECOND_PREFIX = 8'hF0;
  localparam logic [1:0] PTR_INDEX_MAX = 2'h2;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } mod_phase_type;
  typedef enum logic [4:0] {
    ST_FETCH = 5'h01,
    ST_PTR_LOW = 5'h02,
    ST_FF_DEST = 5'h04,
    ST_FF_SKIP = 5'h08,
    ST_IDLE = 5'h10
  } mod_state_type;
endpackage
